// ---- logic/io_port_pkg.sv ----
package io_port_pkg;

   // =========================================================================
   // port geometry
   localparam int unsigned PIN_COUNT   = 8;
   localparam int unsigned DM_WIDTH    = 3;

   // =========================================================================
   // drive modes
   localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_RES_PULLUP  = 3'h2;
   localparam logic [2:0] DM_RES_PULLDN  = 3'h3;
   localparam logic [2:0] DM_OD_LOW      = 3'h4;
   localparam logic [2:0] DM_STRONG      = 3'h6;

   // =========================================================================
   // reset values
   localparam logic [7:0] PIN_OUT_RESET  = 8'h00;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] DETECT_RESET   = 8'h00;

   // =========================================================================
   // timing: reset-release load of the stored per-port setting, in cycles
   localparam int unsigned LOAD_DELAY_CYCLES = 1;

   typedef enum logic [1:0] {
      EDGE_OFF     = 2'h0,
      EDGE_RISE    = 2'h1,
      EDGE_FALL    = 2'h2,
      EDGE_BOTH    = 2'h3
   } edge_mode_t;

   typedef struct packed {
      logic [7:0]               pin_out;
      logic [7:0][2:0]          drive_mode;
   } pin_cfg_t;

   typedef enum logic [2:0] {
      ST_HOLD  = 3'b001,
      ST_LOAD  = 3'b010,
      ST_RUN   = 3'b100
   } port_state_t;

endpackage

// ---- logic/port_interrupt_unit.sv ----
`timescale 1ns/1ns
module port_interrupt_unit
   import io_port_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             pin_in,
   input  wire edge_mode_t [7:0]       edge_mode,
   input  wire logic [7:0]             status_clear,
   output logic [7:0]                  status,
   output logic                        irq
);

   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] stat;
      logic       irq;
      logic       armed;
   } port_interrupt_unit_state_t;

   port_interrupt_unit_state_t s_q;
   port_interrupt_unit_state_t s_d;
   logic [7:0]  hit;

   // =========================================================================
   // edge detection, one per pin
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         always_comb begin
            // no events until the previous level has been sampled once after reset
            unique case (edge_mode[g])
               EDGE_RISE: hit[g] = s_q.armed & pin_in[g] & ~s_q.prev[g];
               EDGE_FALL: hit[g] = s_q.armed & ~pin_in[g] & s_q.prev[g];
               EDGE_BOTH: hit[g] = s_q.armed & (pin_in[g] ^ s_q.prev[g]);
               EDGE_OFF:  hit[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   always_comb begin
      s_d      = s_q;
      s_d.prev = pin_in;
      s_d.armed = 1'b1;
      // set wins over clear
      s_d.stat = (s_q.stat & ~status_clear) | hit;
      s_d.irq  = |s_d.stat;
   end

   // no low-power gating: keeps running in every sleep mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.stat;
   assign irq    = s_q.irq;

   a_status_sets: assert property (@(posedge clock) disable iff (!rst_n)
      hit != 8'h00 |=> (status & $past(hit)) == $past(hit))
      else $error("status bit not set on pin event");
   a_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
      (status != 8'h00) |-> irq)
      else $error("interrupt request missing with status set");
   a_edge_off: assert property (@(posedge clock) disable iff (!rst_n)
      (edge_mode[0] == EDGE_OFF) |-> !hit[0])
      else $error("disabled pin raised an event");

endmodule

// ---- logic/io_port_reset_lowpower_ctrl.sv ----
`timescale 1ns/1ns
module io_port_reset_lowpower_ctrl
   import io_port_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   reset_n,
   input  wire logic                   nv_pull_up,
   input  wire logic                   cfg_write,
   input  wire pin_cfg_t               cfg_data,
   input  wire edge_mode_t [7:0]       edge_mode,
   input  wire logic [7:0]             status_clear,
   input  wire logic                   low_power,
   input  wire logic                   i2c_match,
   input  wire logic                   i2c_on_special_pin,
   input  wire logic [7:0]             pin_in,
   input  wire logic                   scan_mode,
   input  wire logic                   scan_shift,
   input  wire logic                   scan_capture,
   input  wire logic                   scan_update,
   input  wire logic                   scan_in,
   output logic                        scan_out,
   output pin_cfg_t                    pin_cfg,
   output logic                        reset_pull_up,
   output logic [7:0]                  int_status,
   output logic                        port_irq,
   output logic                        wake
);

   typedef struct packed {
      port_state_t state;
      pin_cfg_t    cfg;
      pin_cfg_t    out;
      logic        pull_up;
      logic [7:0]  stat;
      logic        irq;
      logic        wake;
      logic [7:0]  bsr;
      logic [7:0]  bsr_upd;
      logic        sout;
   } top_state_t;

   top_state_t  s_q;
   top_state_t  s_d;
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   logic [7:0]  port_interrupt_unit_status;
   logic        port_interrupt_unit_irq;

   // =========================================================================
   // reset release through two flip-flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   port_interrupt_unit u_port_interrupt_unit (
      .clock        (clock),
      .rst_n        (rst_n),
      .pin_in       (pin_in),
      .edge_mode    (edge_mode),
      .status_clear (status_clear),
      .status       (port_interrupt_unit_status),
      .irq          (port_interrupt_unit_irq)
   );

   function automatic pin_cfg_t all_mode(input logic [2:0] m, input logic [7:0] o);
      pin_cfg_t c;
      c.pin_out = o;
      for (int i = 0; i < 8; i++) begin
         c.drive_mode[i] = m;
      end
      return c;
   endfunction

   // =========================================================================
   // configuration state machine
   always_comb begin
      s_d         = s_q;
      s_d.stat    = port_interrupt_unit_status;
      s_d.irq     = port_interrupt_unit_irq;
      // i2c match wakes only via the special pins
      s_d.wake    = low_power & (port_interrupt_unit_irq | (i2c_match & i2c_on_special_pin));
      unique case (s_q.state)
         ST_HOLD: begin
            s_d.state = ST_LOAD;
         end
         ST_LOAD: begin
            // stored setting applied without software
            s_d.pull_up = nv_pull_up;
            s_d.cfg     = all_mode(nv_pull_up ? DM_RES_PULLUP : DM_RES_PULLDN,
                                   nv_pull_up ? 8'hFF : PIN_OUT_RESET);
            s_d.state   = ST_RUN;
         end
         ST_RUN: begin
            if (cfg_write && !low_power) begin
               s_d.cfg = cfg_data;
            end
         end
      endcase
      // boundary scan register spans every pin
      if (scan_capture) begin
         s_d.bsr = pin_in;
      end else if (scan_shift) begin
         s_d.bsr = {scan_in, s_q.bsr[7:1]};
      end
      if (scan_update) begin
         s_d.bsr_upd = s_q.bsr;
      end
      s_d.sout = s_q.bsr[0];
      s_d.out  = scan_mode ? all_mode(DM_STRONG, s_d.bsr_upd) : s_d.cfg;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // every pin analog high-impedance while reset is held
         s_q         <= '0;
         s_q.state   <= ST_HOLD;
         s_q.cfg     <= all_mode(DM_HIZ_ANALOG, PIN_OUT_RESET);
         s_q.out     <= all_mode(DM_HIZ_ANALOG, PIN_OUT_RESET);
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_cfg       = s_q.out;
   assign reset_pull_up = s_q.pull_up;
   assign int_status    = s_q.stat;
   assign port_irq      = s_q.irq;
   assign wake          = s_q.wake;
   assign scan_out      = s_q.sout;

   // =========================================================================
   // checks
   a_reset_hiz: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> pin_cfg.drive_mode[0] == DM_HIZ_ANALOG)
      else $error("pin not high-z analog at reset release");
   a_nv_load: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.state == ST_LOAD && !scan_mode |=> reset_pull_up == $past(nv_pull_up)
      && pin_cfg.drive_mode[0] == ($past(nv_pull_up) ? DM_RES_PULLUP : DM_RES_PULLDN))
      else $error("stored reset setting not loaded");
   a_sleep_hold: assert property (@(posedge clock) disable iff (!rst_n)
      low_power && s_q.state == ST_RUN && !scan_mode && !$past(scan_mode)
      |=> pin_cfg == $past(pin_cfg))
      else $error("pin state changed in low power");
   a_sleep_nowr: assert property (@(posedge clock) disable iff (!rst_n)
      low_power && cfg_write && s_q.state == ST_RUN |=> s_q.cfg == $past(s_q.cfg))
      else $error("configuration written in low power");
   a_cfg_write: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.state == ST_RUN && cfg_write && !low_power |=> s_q.cfg == $past(cfg_data))
      else $error("configuration write not taken while awake");
   a_scan_drive: assert property (@(posedge clock) disable iff (!rst_n)
      scan_mode |=> pin_cfg.drive_mode[0] == DM_STRONG)
      else $error("scan mode did not drive the pins");
   a_wake_pin: assert property (@(posedge clock) disable iff (!rst_n)
      low_power && port_interrupt_unit_irq |=> wake)
      else $error("pin interrupt did not wake");
   a_i2c_wake: assert property (@(posedge clock) disable iff (!rst_n)
      low_power && i2c_match && !i2c_on_special_pin && !port_interrupt_unit_irq |=> !wake)
      else $error("i2c wake from ordinary pin");
   a_scan_shift: assert property (@(posedge clock) disable iff (!rst_n)
      scan_shift && !scan_capture ##1 1 |-> s_q.bsr[7] == $past(scan_in))
      else $error("scan chain did not shift");

endmodule

// ---- tb/pin_world.sv ----
`timescale 1ns/1ns
module pin_world
   import io_port_pkg::*;
(
   input  wire logic       clock,
   input  wire pin_cfg_t   pin_cfg,
   input  wire logic [7:0] ext_level,
   input  wire logic [7:0] ext_drive,
   output logic [7:0]      pin_in
);
   logic [7:0] float_q = 8'h00;
   // an undriven pin wanders every cycle
   always @(posedge clock) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (ext_drive[i]) pin_in[i] = ext_level[i];
         else if (pin_cfg.drive_mode[i] == DM_RES_PULLUP) pin_in[i] = 1'b1;
         else if (pin_cfg.drive_mode[i] == DM_RES_PULLDN) pin_in[i] = 1'b0;
         else if (pin_cfg.drive_mode[i] == DM_STRONG) pin_in[i] = pin_cfg.pin_out[i];
         else pin_in[i] = float_q[i];
      end
   end
endmodule

// ---- tb/io_port_reset_lowpower_ctrl_bench.sv ----
`timescale 1ns/1ns
module io_port_reset_lowpower_ctrl_bench
   import io_port_pkg::*;
;
   logic clock = 0, reset_n = 0, nv_pull_up = 1, cfg_write = 0, low_power = 0;
   logic i2c_match = 0, i2c_on_special_pin = 0, scan_shift = 0, scan_capture = 0;
   logic scan_in = 0, scan_out, reset_pull_up, port_irq, wake;
   logic scan_mode = 0, scan_update = 0;
   logic [7:0] status_clear = 0, int_status, pin_in, ext_level = 0;
   pin_cfg_t cfg_data = '0, pin_cfg, hold;
   edge_mode_t [7:0] edge_mode = '{default: EDGE_OFF};
   logic [31:0] seed = 52;
   logic [7:0] a, b, h;
   int mismatches = 0, comparisons = 0;
   always #5 clock = ~clock;
   io_port_reset_lowpower_ctrl uut (.clock(clock), .reset_n(reset_n), .nv_pull_up(nv_pull_up),
      .cfg_write(cfg_write), .cfg_data(cfg_data), .edge_mode(edge_mode),
      .status_clear(status_clear), .low_power(low_power), .i2c_match(i2c_match),
      .i2c_on_special_pin(i2c_on_special_pin), .pin_in(pin_in), .scan_mode(scan_mode),
      .scan_shift(scan_shift), .scan_capture(scan_capture), .scan_update(scan_update),
      .scan_in(scan_in), .scan_out(scan_out), .pin_cfg(pin_cfg),
      .reset_pull_up(reset_pull_up), .int_status(int_status), .port_irq(port_irq), .wake(wake));
   pin_world far (.clock(clock), .pin_cfg(pin_cfg), .ext_level(ext_level),
      .ext_drive(8'hFF), .pin_in(pin_in));
   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] hits(edge_mode_t m, logic [7:0] o, logic [7:0] n);
      return ((m == EDGE_RISE || m == EDGE_BOTH) ? (~o & n) : 8'h00) |
             ((m == EDGE_FALL || m == EDGE_BOTH) ? (o & ~n) : 8'h00);
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic do_reset(logic pu);
      pin_cfg_t e;
      reset_n = 0;
      nv_pull_up = pu;
      cyc(2);
      chk(pin_cfg, 32'h0000_0000);
      reset_n = 1;
      cyc(8);
      e.pin_out = pu ? 8'hFF : 8'h00;
      e.drive_mode = {8{pu ? DM_RES_PULLUP : DM_RES_PULLDN}};
      chk(pin_cfg, e);
      chk(reset_pull_up, pu);
   endtask
   task automatic rnd_cfg();
      logic [2:0] legal [3] = '{DM_HIZ_ANALOG, DM_HIZ_DIGITAL, DM_OD_LOW};
      seed = xs(seed);
      cfg_data.pin_out = seed[7:0];
      for (int i = 0; i < 8; i++) cfg_data.drive_mode[i] = legal[seed[8+2*i+:2] % 3];
   endtask
   task automatic end_of_test();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
   initial begin
      cyc(2);
      do_reset(1'b1);
      do_reset(1'b0);
      hold = pin_cfg_t'({8'h00, {8{DM_RES_PULLDN}}});
      for (int t = 0; t < 8; t++) begin
         low_power = t[0];
         rnd_cfg();
         cfg_write = 1;
         cyc(1);
         rnd_cfg();
         cyc(1);
         cfg_write = 0;
         cyc(3);
         if (!low_power) hold = cfg_data;
         chk(pin_cfg, hold);
      end
      for (int t = 0; t < 16; t++) begin
         seed = xs(seed);
         a = seed[7:0];
         b = seed[15:8];
         low_power = seed[16];
         edge_mode = '{default: edge_mode_t'(t % 4)};
         ext_level = a;
         cyc(4);
         status_clear = 8'hFF;
         cyc(1);
         status_clear = 8'h00;
         cyc(4);
         chk(int_status, 8'h00);
         ext_level = b;
         cyc(4);
         h = hits(edge_mode_t'(t % 4), a, b);
         chk(int_status, h);
         chk(port_irq, |h);
         chk(wake, low_power & |h);
      end
      status_clear = 8'hFF;
      cyc(1);
      status_clear = 8'h00;
      low_power = 1;
      for (int s = 0; s < 2; s++) begin
         i2c_on_special_pin = s[0];
         i2c_match = 1;
         cyc(3);
         chk(wake, s[0]);
         i2c_match = 0;
         cyc(3);
      end
      low_power = 0;
      h = 8'h5C;
      ext_level = 8'hA6;
      cyc(2);
      scan_capture = 1;
      cyc(1);
      scan_capture = 0;
      for (int i = 0; i < 8; i++) begin
         cyc(2);
         chk(scan_out, ext_level[i]);
         scan_in = h[i];
         scan_shift = 1;
         cyc(1);
         scan_shift = 0;
      end
      scan_update = 1;
      cyc(1);
      scan_update = 0;
      scan_mode = 1;
      cyc(2);
      chk(pin_cfg, pin_cfg_t'({h, {8{DM_STRONG}}}));
      scan_mode = 0;
      cyc(2);
      end_of_test();
   end
endmodule
